// [verilog/snl_pkg.sv]
// Purpose: Shared constants and types of the scanner host nibble link.
// Assumes: Core clock of 100 MHz; all times are rounded to whole cycles.
// Notes:   Least times round up, longest times round down.
`default_nettype none
package snl_pkg;

    // Core clock rate
    localparam int CLK_MHZ        = 100;

    // Idle low time after which the link falls back to nibble mode
    localparam int MODE_HOLD_NS   = 20000;
    localparam int MODE_HOLD_CYC  = (MODE_HOLD_NS * CLK_MHZ + 999) / 1000;

    // High time that a session's first strobe phase may not reach
    localparam int FIRST_HIGH_NS  = 10000;
    localparam int FIRST_HIGH_CYC = (FIRST_HIGH_NS * CLK_MHZ) / 1000;

    // Width of the strobe stability counter
    localparam int STB_CNT_W      = 12;

    // Bit-serial clock half period in core cycles (default)
    localparam int SCLK_HALF_CYC  = 50;

    // Byte and frame geometry
    localparam int BYTE_W         = 8;
    localparam int FRAME_BITS     = 10;
    localparam int FIFO_DEPTH     = 16;

    // Nibble line patterns
    localparam logic [3:0] NIB_IDLE    = 4'hF;
    localparam logic [3:0] NIB_RX_STAT = 4'h6;

    // Nibble mode sequencer states
    typedef enum logic [2:0] {
        SNL_IDLE,
        SNL_HI_SHOWN,
        SNL_LO_SHOWN,
        SNL_EOR_WAIT,
        SNL_RECV
    } snl_nib_state_t;

endpackage
`default_nettype wire

// [verilog/snl_fifo.sv]
// Purpose: Byte FIFO between the user side and the host link.
// Assumes: Single clock; synchronous active-low reset.
// Notes:   Full and empty are registered so the ready/valid outputs are flops.
`timescale 1ns/1ps
`default_nettype none
module snl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      cnt_r;
    logic [AW:0]      cnt_nxt;
    logic             empty_r;
    logic             push;
    logic             pop;

    assign push      = in_valid & in_ready;
    assign pop       = out_ready & ~empty_r;
    assign out_valid = ~empty_r;
    assign out_data  = mem[rd_ptr_r];

    // Occupancy after this cycle's push and pop
    always_comb begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    // Storage write; no reset needed for data words
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // Pointers, count and flags
    always_ff @(posedge clock) begin
        if (!nrst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
            in_ready <= 1'b1;
            empty_r  <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            cnt_r   <= cnt_nxt;
            in_ready <= (cnt_nxt != (AW+1)'(DEPTH));
            empty_r <= (cnt_nxt == '0);
        end
    end
endmodule
`default_nettype wire

// [verilog/snl_frame.sv]
// Purpose: 10-bit start/stop framer and deframer for bit-serial mode.
// Assumes: Ticks come from the scanner-made serial clock, one per bit.
// Notes:   Data goes least significant bit first; a bad stop bit drops the byte.
`timescale 1ns/1ps
`default_nettype none
module snl_frame
    import snl_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              nrst,
    input  wire logic              tx_tick,
    input  wire logic              rx_tick,
    input  wire logic              tx_valid,
    input  wire logic [BYTE_W-1:0] tx_data,
    output logic                   tx_take,
    output logic                   line_out,
    input  wire logic              line_in,
    output logic [BYTE_W-1:0]      rx_data,
    output logic                   rx_valid
);
    logic [BYTE_W:0]   tx_sh_r;
    logic [3:0]        tx_cnt_r;
    logic [BYTE_W-1:0] rx_sh_r;
    logic [3:0]        rx_cnt_r;

    // A byte is taken only at a frame boundary
    assign tx_take = tx_tick & (tx_cnt_r == 4'h0) & tx_valid;

    // Transmit shifter: start bit, data LSb first, stop bit
    always_ff @(posedge clock) begin
        if (!nrst) begin
            tx_sh_r  <= '1;
            tx_cnt_r <= 4'h0;
            line_out <= 1'b1;
        end else if (tx_tick) begin
            if (tx_cnt_r != 4'h0) begin
                line_out <= tx_sh_r[0];
                tx_sh_r  <= {1'b1, tx_sh_r[BYTE_W:1]};
                tx_cnt_r <= tx_cnt_r - 4'h1;
            end else if (tx_valid) begin
                line_out <= 1'b0;
                tx_sh_r  <= {1'b1, tx_data};
                tx_cnt_r <= 4'(FRAME_BITS - 1);
            end else begin
                line_out <= 1'b1;
            end
        end
    end

    // Receive deframer sampled on the opposite clock phase
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rx_sh_r  <= '0;
            rx_cnt_r <= 4'h0;
            rx_data  <= '0;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (rx_tick) begin
                if (rx_cnt_r == 4'h0) begin
                    if (!line_in) begin
                        rx_cnt_r <= 4'h1;
                    end
                end else if (rx_cnt_r == 4'(FRAME_BITS - 1)) begin
                    rx_cnt_r <= 4'h0;
                    if (line_in) begin
                        rx_data  <= rx_sh_r;
                        rx_valid <= 1'b1;
                    end
                end else begin
                    rx_sh_r  <= {line_in, rx_sh_r[BYTE_W-1:1]};
                    rx_cnt_r <= rx_cnt_r + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [verilog/snl_top.sv]
// Purpose: Scanner end of the host link, nibble mode and bit-serial mode.
// Assumes: Host pins arrive asynchronously and pass two flops first.
// Notes:   Session meaning of bytes is left to the user side logic.
`timescale 1ns/1ps
`default_nettype none
module snl_top
    import snl_pkg::*;
#(
    parameter int SCLK_HALF = SCLK_HALF_CYC,
    parameter int DEPTH     = FIFO_DEPTH
) (
    input  wire logic              clock,
    input  wire logic              nrst,
    input  wire logic              strobe_pin,
    input  wire logic              host_serial_out,
    input  wire logic              txd_pin,
    output logic [3:0]             nibble_lines,
    output logic                   sclk,
    output logic                   rxd,
    output logic                   bitser_mode,
    input  wire logic [snl_pkg::BYTE_W-1:0] tx_data,
    input  wire logic              tx_valid,
    output logic                   tx_ready,
    output logic [snl_pkg::BYTE_W-1:0]      rx_data,
    output logic                   rx_valid,
    output logic                   sess_active,
    output logic [snl_pkg::BYTE_W-1:0]      sess_wake,
    input  wire logic              sess_close
);
    import snl_pkg::*;

    localparam int DIV_W = $clog2(SCLK_HALF + 1);

    // Synchronisers and edge history
    logic                  stb_s1_r;
    logic                  stb_s2_r;
    logic                  stb_q_r;
    logic                  hsd_s1_r;
    logic                  hsd_s2_r;
    logic                  txd_s1_r;
    logic                  txd_s2_r;
    logic                  stb_rise;
    logic                  stb_fall;
    logic                  stb_edge;

    // Mode detection
    logic [STB_CNT_W-1:0]  stb_cnt_r;

    // Nibble sequencer
    snl_nib_state_t        nst_r;
    logic [2:0]            bit_cnt_r;
    logic [BYTE_W-1:0]     nib_sh_r;
    logic                  rx_tog_r;
    logic                  nib_pop;
    logic                  nib_byte_done;
    logic [BYTE_W-1:0]     nib_byte;

    // FIFO read side
    logic                  q_valid;
    logic                  q_ready;
    logic [BYTE_W-1:0]     q_data;

    // Bit-serial clock and framer
    logic [DIV_W-1:0]      div_cnt_r;
    logic                  sclk_fall;
    logic                  sclk_rise;
    logic                  frm_take;
    logic                  frm_rx_valid;
    logic [BYTE_W-1:0]     frm_rx_data;

    // Host pins pass two flops before anything reads them
    always_ff @(posedge clock) begin
        if (!nrst) begin
            stb_s1_r  <= 1'b0;
            stb_s2_r  <= 1'b0;
            stb_q_r   <= 1'b0;
            hsd_s1_r  <= 1'b0;
            hsd_s2_r  <= 1'b0;
            txd_s1_r  <= 1'b1;
            txd_s2_r  <= 1'b1;
        end else begin
            stb_s1_r  <= strobe_pin;
            stb_s2_r  <= stb_s1_r;
            stb_q_r   <= stb_s2_r;
            hsd_s1_r  <= host_serial_out;
            hsd_s2_r  <= hsd_s1_r;
            txd_s1_r  <= txd_pin;
            txd_s2_r  <= txd_s1_r;
        end
    end

    assign stb_rise = stb_s2_r & ~stb_q_r;
    assign stb_fall = ~stb_s2_r & stb_q_r;
    assign stb_edge = stb_rise | stb_fall;

    // Cycles the strobe has held its level, saturating
    always_ff @(posedge clock) begin
        if (!nrst) begin
            stb_cnt_r <= '0;
        end else if (stb_edge) begin
            stb_cnt_r <= '0;
        end else if (stb_cnt_r != '1) begin
            stb_cnt_r <= stb_cnt_r + 1'b1;
        end
    end

    // Mode follows the strobe idle level with no software involved.
    // A long first high outside a session is taken as a bit-serial host,
    // so a nibble host must keep that phase short.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            bitser_mode <= 1'b0;
        end else if (!bitser_mode && stb_q_r && !sess_active
                     && stb_cnt_r >= STB_CNT_W'(FIRST_HIGH_CYC)) begin
            bitser_mode <= 1'b1;
        end else if (bitser_mode && !stb_q_r
                     && stb_cnt_r >= STB_CNT_W'(MODE_HOLD_CYC)) begin
            bitser_mode <= 1'b0;
        end
    end

    // Byte assembled from host bits, MSb first so the LSb ends the byte
    assign nib_byte      = {nib_sh_r[BYTE_W-2:0], hsd_s2_r};
    assign nib_byte_done = stb_edge && (nst_r == SNL_RECV || nst_r == SNL_IDLE)
                           && !(nst_r == SNL_IDLE && q_valid)
                           && bit_cnt_r == 3'h7;
    assign nib_pop       = !bitser_mode && nst_r == SNL_HI_SHOWN && stb_fall;

    // Nibble mode sequencer: strobe edges pace both directions.
    // Lines change on an edge, three cycles after it at most, well inside
    // the host's read delay; a receive timeout or bit-serial mode sets idle alone.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            nst_r        <= SNL_IDLE;
            nibble_lines <= NIB_IDLE;
            bit_cnt_r    <= 3'h0;
            nib_sh_r     <= '0;
            rx_tog_r     <= 1'b0;
        end else if (bitser_mode) begin
            nst_r        <= SNL_IDLE;
            nibble_lines <= NIB_IDLE;
            bit_cnt_r    <= 3'h0;
        end else begin
            unique case (nst_r)
                SNL_IDLE: begin
                    if (stb_rise && q_valid) begin
                        nibble_lines <= q_data[7:4];
                        nst_r        <= SNL_HI_SHOWN;
                    end else if (stb_edge) begin
                        nib_sh_r     <= nib_byte;
                        bit_cnt_r    <= 3'h1;
                        nibble_lines <= {NIB_RX_STAT[3:1], rx_tog_r};
                        nst_r        <= SNL_RECV;
                    end
                end
                SNL_HI_SHOWN: begin
                    if (stb_fall) begin
                        nibble_lines <= q_data[3:0];
                        nst_r        <= SNL_LO_SHOWN;
                    end
                end
                SNL_LO_SHOWN: begin
                    if (stb_rise && q_valid) begin
                        nibble_lines <= q_data[7:4];
                        nst_r        <= SNL_HI_SHOWN;
                    end else if (stb_rise) begin
                        nst_r        <= SNL_EOR_WAIT;
                    end
                end
                SNL_EOR_WAIT: begin
                    if (stb_fall) begin
                        nibble_lines <= NIB_IDLE;
                        nst_r        <= SNL_IDLE;
                    end
                end
                SNL_RECV: begin
                    if (stb_edge) begin
                        nib_sh_r  <= nib_byte;
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_cnt_r == 3'h7) begin
                            rx_tog_r     <= ~rx_tog_r;
                            nibble_lines <= {NIB_RX_STAT[3:1], ~rx_tog_r};
                        end
                    end else if (bit_cnt_r == 3'h0
                                 && stb_cnt_r >= STB_CNT_W'(MODE_HOLD_CYC)) begin
                        // Host stopped sending on a byte boundary
                        nst_r        <= SNL_IDLE;
                        nibble_lines <= NIB_IDLE;
                    end
                end
                default: nst_r <= SNL_IDLE;
            endcase
        end
    end

    // Outgoing bytes queue here; a full FIFO stalls the user side
    snl_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clock     (clock),
        .nrst      (nrst),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (q_valid),
        .out_ready (q_ready),
        .out_data  (q_data)
    );

    assign q_ready = bitser_mode ? frm_take : nib_pop;

    // Scanner-made serial clock; idles high outside bit-serial mode
    always_ff @(posedge clock) begin
        if (!nrst) begin
            div_cnt_r <= '0;
            sclk      <= 1'b1;
        end else if (!bitser_mode) begin
            div_cnt_r <= '0;
            sclk      <= 1'b1;
        end else if (div_cnt_r == DIV_W'(SCLK_HALF - 1)) begin
            div_cnt_r <= '0;
            sclk      <= ~sclk;
        end else begin
            div_cnt_r <= div_cnt_r + 1'b1;
        end
    end

    // Data changes on the falling clock edge, is sampled on the rising one
    assign sclk_fall = bitser_mode && sclk
                       && div_cnt_r == DIV_W'(SCLK_HALF - 1);
    assign sclk_rise = bitser_mode && !sclk
                       && div_cnt_r == DIV_W'(SCLK_HALF - 1);

    // Framing held in reset outside bit-serial mode, so no half frame lingers
    snl_frame u_frame (
        .clock    (clock),
        .nrst     (nrst & bitser_mode),
        .tx_tick  (sclk_fall),
        .rx_tick  (sclk_rise),
        .tx_valid (q_valid & bitser_mode),
        .tx_data  (q_data),
        .tx_take  (frm_take),
        .line_out (rxd),
        .line_in  (txd_s2_r),
        .rx_data  (frm_rx_data),
        .rx_valid (frm_rx_valid)
    );

    // Received bytes from either mode, one-cycle strobe
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rx_data  <= '0;
            rx_valid <= 1'b0;
        end else if (frm_rx_valid) begin
            rx_data  <= frm_rx_data;
            rx_valid <= 1'b1;
        end else if (nib_byte_done && !bitser_mode) begin
            rx_data  <= nib_byte;
            rx_valid <= 1'b1;
        end else begin
            rx_valid <= 1'b0;
        end
    end

    // Session tracking: the first byte either way is the wakeup code.
    // Opening beats a close in the same cycle so no wakeup is lost.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            sess_active <= 1'b0;
            sess_wake   <= '0;
        end else if (!sess_active && (frm_rx_valid
                     || (nib_byte_done && !bitser_mode))) begin
            sess_active <= 1'b1;
            sess_wake   <= frm_rx_valid ? frm_rx_data : nib_byte;
        end else if (!sess_active && q_ready && q_valid) begin
            sess_active <= 1'b1;
            sess_wake   <= q_data;
        end else if (sess_close) begin
            sess_active <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [verification/snl_chk_sva.sv]
// Purpose: Port-level assertions for the scanner host link.
// Assumes: Raw strobe pin here; the design adds two sync flops.
// Notes:   Mode run lengths allow a few cycles for the synchronizers.
`timescale 1ns/1ps
`default_nettype none
module snl_chk
    import snl_pkg::*;
#(
    parameter int SCLK_HALF = 50,
    parameter int DEPTH     = 16
) (
    input wire logic              clock,
    input wire logic              nrst,
    input wire logic              strobe_pin,
    input wire logic              host_serial_out,
    input wire logic              txd_pin,
    input wire logic [3:0]        nibble_lines,
    input wire logic              sclk,
    input wire logic              rxd,
    input wire logic              bitser_mode,
    input wire logic [BYTE_W-1:0] tx_data,
    input wire logic              tx_valid,
    input wire logic              tx_ready,
    input wire logic [BYTE_W-1:0] rx_data,
    input wire logic              rx_valid,
    input wire logic              sess_active,
    input wire logic [BYTE_W-1:0] sess_wake,
    input wire logic              sess_close
);
    logic [11:0] hi_r;
    logic [11:0] lo_r;
    logic [11:0] hc_r;
    logic [5:0]  st_r;
    logic        sd_r;
    logic        seen_r;

    // Run lengths of the raw strobe level, saturating
    always_ff @(posedge clock) begin
        if (!nrst) begin
            hi_r <= 12'h000;
            lo_r <= 12'h000;
        end else begin
            hi_r <= strobe_pin ? hi_r + {11'h000, ~&hi_r} : 12'h000;
            lo_r <= strobe_pin ? 12'h000 : lo_r + {11'h000, ~&lo_r};
        end
    end

    // Recent strobe samples and sclk level lengths; first level is partial
    always_ff @(posedge clock) begin
        st_r   <= {st_r[4:0], strobe_pin};
        sd_r   <= sclk;
        hc_r   <= (sclk != sd_r) ? 12'h001 : hc_r + 12'h001;
        seen_r <= nrst & bitser_mode & (seen_r | (sclk != sd_r));
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    chk_reset_idle: assert property (
        $rose(nrst) |-> nibble_lines == NIB_IDLE && sclk && rxd
            && !bitser_mode && !sess_active && !rx_valid)
        else $error("outputs not idle after reset");
    chk_rx_pulse: assert property (
        rx_valid |=> !rx_valid) else $error("rx_valid wider than a cycle");
    chk_serial_idle: assert property (
        !bitser_mode [*3] |-> sclk && rxd) else $error("sclk or rxd busy");
    chk_sclk_half: assert property (
        seen_r && bitser_mode && sd_r && !sclk |-> hc_r == SCLK_HALF)
        else $error("sclk high phase has wrong length");
    chk_nib_hold: assert property (
        $changed(nibble_lines) && nibble_lines != NIB_IDLE
            |-> st_r[4:0] != st_r[5:1])
        else $error("nibble lines moved without a strobe edge");
    chk_ready_push: assert property (
        $fell(tx_ready) |-> $past(tx_valid))
        else $error("tx_ready fell without a push");
    chk_wake_hold: assert property (
        $past(sess_active, 2) && $past(sess_active) && !$past(sess_close)
            |-> $stable(sess_wake))
        else $error("wakeup code changed inside a session");
    chk_close_cause: assert property (
        $fell(sess_active) |-> $past(sess_close))
        else $error("session closed without a close pulse");
    chk_mode_up: assert property (
        $rose(bitser_mode) |-> hi_r >= FIRST_HIGH_CYC
            && hi_r <= FIRST_HIGH_CYC + 8)
        else $error("bit-serial mode entered at wrong time");
    chk_mode_down: assert property (
        $fell(bitser_mode) |-> lo_r >= MODE_HOLD_CYC
            && lo_r <= MODE_HOLD_CYC + 8)
        else $error("nibble mode entered at wrong time");
endmodule

bind snl_top snl_chk #(.SCLK_HALF(SCLK_HALF), .DEPTH(DEPTH)) u_chk (
    .clock(clock), .nrst(nrst), .strobe_pin(strobe_pin),
    .host_serial_out(host_serial_out), .txd_pin(txd_pin),
    .nibble_lines(nibble_lines), .sclk(sclk), .rxd(rxd),
    .bitser_mode(bitser_mode), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .sess_active(sess_active), .sess_wake(sess_wake),
    .sess_close(sess_close)
);
`default_nettype wire

// [verification/snl_host.sv]
// Purpose: Host serial port model paced by software.
// Assumes: Strobe phases of 80 ns, 120 ns when sending, well above the nibble answer time.
// Notes:   Serial-out is inverted once its hold has run out.
`timescale 1ns/1ps
`default_nettype none
module snl_host (
    output logic            strobe_pin,
    output logic            host_serial_out,
    output logic            txd_pin,
    input  wire logic [3:0] nibble_lines,
    input  wire logic       sclk,
    input  wire logic       rxd
);
    logic [7:0] got_r;
    logic [3:0] stat_r;
    logic       stop_r;
    int         got_n = 0;

    // Strobe idles low for nibble mode, txd at mark
    initial begin
        strobe_pin = 1'b0;
        host_serial_out = 1'b0;
        txd_pin = 1'b1;
    end

    // Hold the strobe at the mode level before a packet
    task automatic hold(input logic lvl, input int ns);
        #3;
        strobe_pin = lvl;
        #(ns);
    endtask

    // One strobe edge; the lines are read late in the phase
    task automatic step(input logic lvl);
        strobe_pin = lvl;
        #75;
        stat_r = nibble_lines;
        #5;
    endtask

    // Read n bytes, upper nibble on the rise, then end the read
    task automatic read_pkt(input int n);
        logic [3:0] hi;
        #3;
        repeat (n) begin
            step(1'b1);
            hi = stat_r;
            step(1'b0);
            got_r = {hi, stat_r};
            got_n++;
        end
        step(1'b1);
        step(1'b0);
    endtask

    // Send a byte MSb first, one bit per strobe edge
    task automatic send_byte(input logic [7:0] b, input logic multi);
        #3;
        for (int i = 7; i >= 0; i--) begin
            host_serial_out = b[i];
            #40;
            step(~strobe_pin);
        end
        host_serial_out = ~b[0];
        if (multi) #50000;
    endtask

    // Take one frame off rxd at sclk rises
    task automatic ser_read();
        int k;
        k = 0;
        do begin
            @(posedge sclk);
            k++;
        end while (rxd !== 1'b0 && k < 4000);
        for (int i = 0; i < 8; i++) begin
            @(posedge sclk);
            got_r[i] = rxd;
        end
        @(posedge sclk);
        stop_r = rxd;
        got_n++;
    endtask

    // Put one frame on txd at sclk falls
    task automatic ser_send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge sclk);
            txd_pin = f[i];
        end
        @(negedge sclk);
    endtask
endmodule
`default_nettype wire

// [verification/tb_scanner_host_nibble_link.sv]
// Purpose: Self-checking bench for the scanner host link.
// Assumes: Host model on the link pins; user side driven here.
// Notes:   sclk half period cut to 4 cycles to keep frames short.
`timescale 1ns/1ps
`default_nettype none
module tb_scanner_host_nibble_link;
    import snl_pkg::*;

    logic       clock = 1'b0;
    logic       nrst = 1'b0;
    logic       strobe_pin;
    logic       host_serial_out;
    logic       txd_pin;
    logic [3:0] nibble_lines;
    logic       sclk;
    logic       rxd;
    logic       bitser_mode;
    logic [7:0] tx_data = 8'h00;
    logic       tx_valid = 1'b0;
    logic       tx_ready;
    logic [7:0] rx_data;
    logic       rx_valid;
    logic       sess_active;
    logic [7:0] sess_wake;
    logic       sess_close = 1'b0;
    logic [7:0] exp_rx[$];
    logic [7:0] exp_rd[$];
    int         bad_count = 0;
    int         cmp_count = 0;
    int         cyc = 0;

    always #5 clock = ~clock;

    snl_top #(.SCLK_HALF(4), .DEPTH(FIFO_DEPTH)) DUT (
        .clock(clock), .nrst(nrst), .strobe_pin(strobe_pin),
        .host_serial_out(host_serial_out), .txd_pin(txd_pin),
        .nibble_lines(nibble_lines), .sclk(sclk), .rxd(rxd),
        .bitser_mode(bitser_mode), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
        .rx_valid(rx_valid), .sess_active(sess_active),
        .sess_wake(sess_wake), .sess_close(sess_close)
    );

    snl_host HOST (
        .strobe_pin(strobe_pin), .host_serial_out(host_serial_out),
        .txd_pin(txd_pin), .nibble_lines(nibble_lines), .sclk(sclk),
        .rxd(rxd)
    );

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        bad_count += exp_rx.size() + exp_rd.size();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Offer a byte and hold it until the buffer takes it
    task automatic push(input logic [7:0] b);
        tx_data <= b;
        tx_valid <= 1'b1;
        exp_rd.push_back(b);
        @(posedge clock);
        while (tx_ready !== 1'b1) @(posedge clock);
    endtask

    // One-cycle close pulse from the user side
    task automatic close_sess();
        @(posedge clock);
        sess_close <= 1'b1;
        @(posedge clock);
        sess_close <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    // Bytes from the host, oldest note first; a stray one is a mismatch
    always @(posedge clock) begin
        if (rx_valid === 1'b1) begin
            cmp(rx_data, exp_rx.size() > 0 ? exp_rx.pop_front() : 8'hXX);
        end
    end

    // Bytes the host model read back
    always @(HOST.got_n) begin
        cmp(HOST.got_r, exp_rd.size() > 0 ? exp_rd.pop_front() : 8'hXX);
    end

    // Cut a hang short; the whole run needs about 20000 cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            bad_count++;
            final_report();
        end
    end

    initial begin
        logic [7:0] b;
        logic [7:0] w;
        void'($urandom(97471));
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        repeat (2) @(posedge clock);
        cmp({4'h0, nibble_lines}, {4'h0, NIB_IDLE});
        cmp({4'h0, bitser_mode, sclk, rxd, sess_active}, 8'h06);
        // Fill the buffer while the host stalls, then knock once more
        push(8'hA5);
        push(8'h00);
        push(8'hFF);
        repeat (13) push(8'($urandom));
        tx_valid <= 1'b0;
        repeat (2) @(posedge clock);
        cmp({7'h00, tx_ready}, 8'h00);
        tx_data <= 8'h3C;
        tx_valid <= 1'b1;
        repeat (3) @(posedge clock);
        tx_valid <= 1'b0;
        // Host drains all sixteen, then ends the read
        HOST.hold(1'b0, 20000);
        HOST.read_pkt(FIFO_DEPTH);
        cmp({4'h0, HOST.stat_r}, {4'h0, NIB_IDLE});
        cmp({7'h00, sess_active}, 8'h01);
        cmp(sess_wake, 8'hA5);
        close_sess();
        cmp({7'h00, sess_active}, 8'h00);
        // Two one-byte packets from the host in nibble mode, the receive timeout between them
        w = 8'($urandom);
        b = 8'($urandom);
        exp_rx.push_back(w);
        exp_rx.push_back(b);
        HOST.hold(1'b0, 20000);
        HOST.send_byte(w, 1'b1);
        cmp({5'h00, HOST.stat_r[3:1]}, 8'h03);
        HOST.send_byte(b, 1'b1);
        cmp({5'h00, HOST.stat_r[3:1]}, 8'h03);
        cmp(sess_wake, w);
        close_sess();
        // Strobe held high with no session selects bit-serial mode
        HOST.hold(1'b1, 20000);
        cmp({7'h00, bitser_mode}, 8'h01);
        b = 8'($urandom);
        exp_rx.push_back(b);
        fork
            HOST.ser_read();
            HOST.ser_send(b);
            begin
                @(posedge clock);
                push(8'($urandom));
                tx_valid <= 1'b0;
            end
        join
        cmp({7'h00, HOST.stop_r}, 8'h01);
        HOST.hold(1'b0, 25000);
        cmp({7'h00, bitser_mode}, 8'h00);
        final_report();
    end
endmodule
`default_nettype wire
